// ### rtl/cdps_top.sv
// top: clock divisor, oscillator select and power-save control with wishbone slave
// Operation
// - with recover_on_interrupt set an interrupt clears slowdown_enable, otherwise it does not.
// - the slowdown ratio code divides the processor clock by 2**code, reset code 011.
// - slowdown_enable on applies the ratio, off forces a 1:1 ratio.
// - a write setting slowdown_enable with a resulting ratio code of 000 leaves slowdown_enable clear.
// - the rc postscaler divides by 1..64 for codes 000..110 and 256 for 111, reset 1.
// - the pll output divider divides by 2, 4 or 8 for codes 00, 01, 11, reset 01, 10 reserved.
// - while unlocked and with no switch pending, a write of a new_osc_select other than the current source starts a clock switch to it.
// - a power_save_instr operand selects sleep or idle.
// - sleep stops all clocks and execution, idle halts only the processor.
// - an enabled interrupt, watchdog time-out or reset wakes the device.
`timescale 1ns/1ps
`default_nettype none
module cdps_top
  import cdps_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // wake sources
  input  wire logic        irq_i,
  input  wire logic        wdt_timeout_i,
  // clock controls
  output logic             cpu_tick_o,
  output logic             cpu_run_o,
  output logic             periph_run_o,
  output logic [7:0]       frc_shift_o,
  output logic [3:0]       pll_div_o,
  output logic [2:0]       osc_sel_o,
  output logic             switch_busy_o
);

  // clock_divisor_control fields
  logic            recover_r;
  logic [2:0]      doze_r;
  logic            slow_en_r;
  logic [2:0]      frc_r;
  logic [1:0]      post_r;
  logic [4:0]      pre_r;
  // oscillator control
  logic [2:0]      nosc_r;
  logic [2:0]      cosc_r;
  logic            lock_r;
  logic [3:0]      sw_cnt_r;
  // power state
  cdps_pwr_t       pwr_r;
  logic            wake_r;
  // wake input synchronisers
  logic [2:0]      irq_sync_r;
  logic [2:0]      wdt_sync_r;
  logic            irq_r;
  logic            wdt_r;
  // bus and slowdown divider
  logic            req;
  logic            wr;
  logic [15:0]     wdata;
  logic            doze_tick;
  logic            div_run;
  logic [7:0]      doze_shift;

  function automatic logic [7:0] frc_shift(input logic [2:0] code);
    frc_shift = (code == 3'h7) ? 8'h08 : {5'h00, code};
  endfunction : frc_shift

  function automatic logic [3:0] pll_div(input logic [1:0] code);
    case (code)
      2'h0:    pll_div = 4'h2;
      2'h1:    pll_div = 4'h4;
      2'h3:    pll_div = 4'h8;
      default: pll_div = 4'h4;
    endcase
  endfunction : pll_div

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr    = req && wb_we_i;
  assign wdata = merge16({recover_r, doze_r, slow_en_r, frc_r, post_r, 1'b0, pre_r},
                         wb_dat_i, wb_sel_i);

  // wishbone answer one cycle after the request, dropped in the next
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_we_i)
    begin
      if (wb_adr_i == ADDR_DIVCTL)
        wb_dat_o <= {16'h0000, recover_r, doze_r, slow_en_r, frc_r, post_r, 1'b0, pre_r};
      else if (wb_adr_i == ADDR_OSCCTL)
        wb_dat_o <= {21'h0, nosc_r, lock_r, 4'h0, cosc_r};
      else if (wb_adr_i == ADDR_STATUS)
        wb_dat_o <= {27'h0, switch_busy_o, wake_r, 1'b0, pwr_r};
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

  // clock_divisor_control
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      recover_r <= 1'b0;
      doze_r    <= DOZE_RST;
      slow_en_r <= 1'b0;
      frc_r   <= FRC_RST;
      post_r  <= POST_RST;
      pre_r   <= PRE_RST;
    end
    else
    begin
      if (wr && wb_adr_i == ADDR_DIVCTL)
      begin
        recover_r <= wdata[RECOVER_BIT];
        frc_r <= wdata[FRC_LSB +: 3];
        pre_r <= wdata[PRE_LSB +: 5];
        if (wdata[POST_LSB +: 2] != POST_RSVD)
          post_r <= wdata[POST_LSB +: 2];
        if (!slow_en_r)
          doze_r <= wdata[DOZE_LSB +: 3];
        if (wdata[SLOW_EN_BIT] && (slow_en_r ? doze_r : wdata[DOZE_LSB +: 3]) == DOZE_ZERO)
          slow_en_r <= 1'b0;
        else
          slow_en_r <= wdata[SLOW_EN_BIT];
      end
      if (irq_r && recover_r)
        slow_en_r <= 1'b0;
    end
  end

  // oscillator select and switch sequencing
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      nosc_r   <= OSC_RST;
      cosc_r   <= OSC_RST;
      lock_r   <= 1'b0;
      sw_cnt_r <= 4'h0;
    end
    else
    begin
      if (wr && wb_adr_i == ADDR_OSCCTL)
      begin
        if (wb_sel_i[0])
          lock_r <= wb_dat_i[LOCK_BIT];
        if (wb_sel_i[1] && !lock_r && sw_cnt_r == 4'h0)
        begin
          nosc_r <= wb_dat_i[NOSC_LSB +: 3];
          if (wb_dat_i[NOSC_LSB +: 3] != cosc_r)
            sw_cnt_r <= SWITCH_CYC;
        end
      end
      else if (sw_cnt_r != 4'h0)
      begin
        sw_cnt_r <= sw_cnt_r - 4'h1;
        if (sw_cnt_r == 4'h1)
          cosc_r <= nosc_r;
      end
    end
  end

  // wake inputs: three stages, a change counts once stages two and three agree
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      irq_sync_r <= 3'h0;
      wdt_sync_r <= 3'h0;
      irq_r      <= 1'b0;
      wdt_r      <= 1'b0;
    end
    else
    begin
      irq_sync_r <= {irq_sync_r[1:0], irq_i};
      wdt_sync_r <= {wdt_sync_r[1:0], wdt_timeout_i};
      if (irq_sync_r[1] == irq_sync_r[2])
        irq_r <= irq_sync_r[2];
      if (wdt_sync_r[1] == wdt_sync_r[2])
        wdt_r <= wdt_sync_r[2];
    end
  end

  // power state
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      pwr_r  <= PS_RUN_ST;
      wake_r <= 1'b0;
    end
    else
    begin
      case (pwr_r)
        PS_RUN_ST:
        begin
          if (wr && wb_adr_i == ADDR_PWRCMD && wb_sel_i[0])
          begin
            if (wb_dat_i[7:0] == PS_SLEEP)
              pwr_r <= PS_SLEEP_ST;
            else if (wb_dat_i[7:0] == PS_IDLE)
              pwr_r <= PS_IDLE_ST;
          end
          if (wr && wb_adr_i == ADDR_STATUS && wb_sel_i[0] && wb_dat_i[2])
            wake_r <= 1'b0;
        end
        PS_IDLE_ST, PS_SLEEP_ST:
        begin
          if (irq_r || wdt_r)
          begin
            pwr_r  <= PS_RUN_ST;
            wake_r <= 1'b1;
          end
        end
        default:
          pwr_r <= PS_RUN_ST;
      endcase
    end
  end

  // slowdown divider
  assign doze_shift = slow_en_r ? {5'h00, doze_r} : 8'h00;
  assign div_run    = (pwr_r == PS_RUN_ST);

  cdps_divider cdps_divider_inst
  (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .run_i   (div_run),
    .shift_i (doze_shift),
    .tick_o  (doze_tick)
  );

  // registered clock outputs
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      cpu_tick_o    <= 1'b0;
      cpu_run_o     <= 1'b1;
      periph_run_o  <= 1'b1;
      frc_shift_o   <= 8'h00;
      pll_div_o     <= 4'h4;
      osc_sel_o     <= OSC_RST;
      switch_busy_o <= 1'b0;
    end
    else
    begin
      cpu_tick_o    <= doze_tick;
      cpu_run_o     <= (pwr_r == PS_RUN_ST);
      periph_run_o  <= (pwr_r != PS_SLEEP_ST);
      frc_shift_o   <= frc_shift(frc_r);
      pll_div_o     <= pll_div(post_r);
      osc_sel_o     <= cosc_r;
      switch_busy_o <= (sw_cnt_r != 4'h0);
    end
  end

endmodule : cdps_top
`default_nettype wire

// ### rtl/cdps_pkg.sv
// package: register map, field layout, reset values and encodings of the clock divisor block
package cdps_pkg;

  // register word addresses (byte addresses, one aligned word each)
  localparam logic [3:0] ADDR_DIVCTL  = 4'h0;
  localparam logic [3:0] ADDR_OSCCTL  = 4'h4;
  localparam logic [3:0] ADDR_PWRCMD  = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hC;

  // clock_divisor_control field positions
  localparam int RECOVER_BIT   = 15;
  localparam int DOZE_LSB      = 12;
  localparam int SLOW_EN_BIT   = 11;
  localparam int FRC_LSB       = 8;
  localparam int POST_LSB      = 6;
  localparam int PRE_LSB       = 0;

  // reset values
  localparam logic [2:0] DOZE_RST  = 3'h3;
  localparam logic [2:0] FRC_RST   = 3'h0;
  localparam logic [1:0] POST_RST  = 2'h1;
  localparam logic [4:0] PRE_RST   = 5'h00;
  localparam logic [2:0] OSC_RST   = 3'h0;
  localparam logic [2:0] DOZE_ZERO = 3'h0;
  localparam logic [1:0] POST_RSVD = 2'h2;

  // osc control register fields
  localparam int NOSC_LSB      = 8;
  localparam int LOCK_BIT      = 7;
  localparam int COSC_LSB      = 0;

  // power save command operands
  localparam logic [7:0] PS_SLEEP  = 8'h00;
  localparam logic [7:0] PS_IDLE   = 8'h01;

  // clock switch takes this many cycles to settle on the new source
  localparam logic [3:0] SWITCH_CYC = 4'h8;

  // power state encoding, one bit from run to idle, two bits from run to sleep
  typedef enum logic [1:0]
  {
    PS_RUN_ST   = 2'b00,
    PS_IDLE_ST  = 2'b01,
    PS_SLEEP_ST = 2'b11
  } cdps_pwr_t;

endpackage : cdps_pkg

// ### rtl/cdps_divider.sv
// divider: programmable power-of-two strobe generator
`timescale 1ns/1ps
`default_nettype none
module cdps_divider
  import cdps_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  // control
  input  wire logic       run_i,
  input  wire logic [7:0] shift_i,
  // strobe out, one cycle in every 2**shift_i for shift_i up to 8
  output logic            tick_o
);

  logic [7:0] cnt_r;
  logic [8:0] period;

  assign period = 9'h001 << shift_i[3:0];

  always_ff @(posedge clock_i)
  begin
    if (srst_i || !run_i)
    begin
      cnt_r  <= 8'h00;
      tick_o <= 1'b0;
    end
    else if ({1'b0, cnt_r} >= period - 9'h001)
    begin
      cnt_r  <= 8'h00;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 8'h01;
      tick_o <= 1'b0;
    end
  end

endmodule : cdps_divider
`default_nettype wire

// ### bench/cdps_top_sva.sv
// checker: port assertions of the clock divisor block
`timescale 1ns/1ps
`default_nettype none
module cdps_top_sva
(
  input wire logic       clock_i,
  input wire logic       srst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       irq_i,
  input wire logic       wdt_timeout_i,
  input wire logic       cpu_run_o,
  input wire logic       periph_run_o,
  input wire logic [7:0] frc_shift_o,
  input wire logic [3:0] pll_div_o,
  input wire logic [2:0] osc_sel_o,
  input wire logic       switch_busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_ack_one: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_reset_vals: assert property ($fell(srst_i) |-> pll_div_o == 4'h4 &&
    frc_shift_o == 8'h00 && osc_sel_o == 3'h0 && cpu_run_o) else $error("reset values");
  a_sleep_halts: assert property (!periph_run_o |-> !cpu_run_o)
    else $error("cpu runs in sleep");
  a_wake_up: assert property (!cpu_run_o && (irq_i && $past(irq_i) ||
    wdt_timeout_i && $past(wdt_timeout_i)) |-> ##5 cpu_run_o)
    else $error("no wake");
  a_switch_end: assert property ($rose(switch_busy_o) |-> ##[1:12] !switch_busy_o)
    else $error("switch hangs");
  a_osc_hold: assert property ($changed(osc_sel_o) |->
    $past(switch_busy_o) || $past(switch_busy_o, 2)) else $error("osc changed alone");
  a_pll_legal: assert property (pll_div_o inside {4'h2, 4'h4, 4'h8})
    else $error("pll divide");
  a_frc_legal: assert property (frc_shift_o inside {[8'h00:8'h06], 8'h08})
    else $error("rc postscale");
  c_idle: cover property (!cpu_run_o && periph_run_o);
  c_sleep: cover property (!periph_run_o);
  c_switch: cover property ($rose(switch_busy_o));
endmodule : cdps_top_sva
bind cdps_top cdps_top_sva cdps_top_sva_inst (.clock_i(clock_i), .srst_i(srst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq_i(irq_i),
  .wdt_timeout_i(wdt_timeout_i), .cpu_run_o(cpu_run_o), .periph_run_o(periph_run_o),
  .frc_shift_o(frc_shift_o), .pll_div_o(pll_div_o), .osc_sel_o(osc_sel_o),
  .switch_busy_o(switch_busy_o));
`default_nettype wire

// ### bench/cdps_top_tb.sv
// testbench: bus, divider, switch and power-save scenarios
`timescale 1ns/1ps
`default_nettype none
module cdps_top_tb;
  import cdps_pkg::*;
  logic        clock_i = 1'b0, srst_i = 1'b1, irq_i = 1'b0, wdt_timeout_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h3, pll_div_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rnd = 32'h0000_004E, rq[$];
  logic        wb_ack_o, cpu_tick_o, cpu_run_o, periph_run_o, switch_busy_o;
  logic [7:0]  frc_shift_o;
  logic [2:0]  osc_sel_o;
  logic [15:0] e;
  logic [1:0]  pv = 2'h0;
  int          n_fail = 0, checked = 0;
  cdps_top cdps_top_inst (.clock_i(clock_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_i(irq_i),
    .wdt_timeout_i(wdt_timeout_i), .cpu_tick_o(cpu_tick_o), .cpu_run_o(cpu_run_o),
    .periph_run_o(periph_run_o), .frc_shift_o(frc_shift_o), .pll_div_o(pll_div_o),
    .osc_sel_o(osc_sel_o), .switch_busy_o(switch_busy_o));
  initial forever #50 clock_i = ~clock_i;
  function automatic void cmp(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endfunction : cmp
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task automatic wb(input logic we, input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0, d};
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    rq.push_back(x);
    wb(1'b0, a, 16'h0);
  endtask : rd
  // read data is compared by the monitor against the oldest note
  always @(posedge clock_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      cmp(wb_dat_o, rq.pop_front());
  task automatic ticks(input int x);
    int n = 0;
    repeat (64) @(posedge clock_i) n += cpu_tick_o;
    cmp(n, x);
  endtask : ticks
  task automatic pls(input bit w);
    @(posedge clock_i);
    if (w) wdt_timeout_i <= 1'b1; else irq_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    wdt_timeout_i <= 1'b0;
    irq_i <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask : pls
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (2000) @(posedge clock_i);
    n_fail++;
    end_sim();
  end
  initial
  begin
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(ADDR_DIVCTL, 32'h3040);
    wb(1'b1, ADDR_DIVCTL, 16'h0800);
    rd(ADDR_DIVCTL, 32'h0);
    rd(4'h2, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      rnd = xs(rnd);
      e = {5'h0, i[2:0], rnd[7:6], 1'b0, rnd[4:0]};
      if (rnd[7:6] == 2'h2) e[7:6] = pv;
      pv = e[7:6];
      wb(1'b1, ADDR_DIVCTL, {5'h0, i[2:0], rnd[7:0]});
      rd(ADDR_DIVCTL, {16'h0, e});
      cmp(frc_shift_o, i == 7 ? 8 : i);
      cmp(pll_div_o, pv == 2'h3 ? 8 : pv * 2 + 2);
    end
    wb(1'b1, ADDR_DIVCTL, 16'h3800);
    ticks(8);
    wb(1'b1, ADDR_DIVCTL, 16'h5800);
    pls(1'b0);
    rd(ADDR_DIVCTL, 32'h3800);
    wb(1'b1, ADDR_DIVCTL, 16'hB800);
    pls(1'b0);
    rd(ADDR_DIVCTL, 32'hB000);
    ticks(64);
    wb(1'b1, ADDR_OSCCTL, 16'h0400);
    repeat (12) @(posedge clock_i);
    cmp(osc_sel_o, 3'h4);
    wb(1'b1, ADDR_PWRCMD, {8'h0, PS_IDLE});
    repeat (3) @(posedge clock_i);
    cmp({cpu_run_o, periph_run_o}, 2'b01);
    pls(1'b1);
    cmp({cpu_run_o, periph_run_o}, 2'b11);
    wb(1'b1, ADDR_PWRCMD, {8'h0, PS_SLEEP});
    repeat (3) @(posedge clock_i);
    cmp({cpu_run_o, periph_run_o}, 2'b00);
    pls(1'b0);
    cmp({cpu_run_o, periph_run_o}, 2'b11);
    end_sim();
  end
endmodule : cdps_top_tb
`default_nettype wire
